// File: pwb_slave.sv
`timescale 1ns/10ps
`default_nettype none
module pwb_slave
	import pwb_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   swd_in,
	output logic        swd_out,
	output logic        swd_oe_n,
	input  wire logic   send_one,
	input  wire logic   attn_req,
	output logic        attn_busy,
	output logic        bit_valid,
	output logic        bit_value,
	output logic        start_seen,
	output logic        reset_seen,
	output logic        attn_done,
	output logic        attn_allowed
);
	import pwb_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pwb_state_e        state;
		logic [CNT_W-1:0]  hi_cnt;
		logic [CNT_W-1:0]  drv_cnt;
		logic              drive;
		logic              drive_attn;
		logic              drive_one;
		logic              attn_pend;
		logic [3:0]        bits_seen;
		logic              allowed;
		logic              bit_valid;
		logic              bit_value;
		logic              start_seen;
		logic              reset_seen;
		logic              attn_done;
	} pwb_regs_s;

	pwb_regs_s         r;
	pwb_regs_s         next_r;
	logic [CNT_W-1:0]  low_cnt;
	logic              line_low;

	assign line_low = !swd_in;

	// ----------------------------------------------------------------
	// Low-duration timer
	// ----------------------------------------------------------------
	pwb_timer u_low_timer
	(
		.clk   (clk),
		.rst   (rst),
		.run   (line_low),
		.count (low_cnt)
	);

	// Classification by duration windows placed between the ranges
	function automatic pwb_sym_e classify(input logic [CNT_W-1:0] len);
		pwb_sym_e s;
		s = PWB_SYM_NONE;
		if (len < 16'(GLITCH_CYC))
			s = PWB_SYM_NONE;
		else if (len < 16'(THR_ZERO_ONE))
			s = PWB_SYM_ZERO;
		else if (len < 16'(THR_ONE_START))
			s = PWB_SYM_ONE;
		else if (len < 16'(THR_START_ATTN))
			s = PWB_SYM_START;
		else if (len < 16'(THR_ATTN_RESET))
			s = PWB_SYM_ATTN;
		else
			s = PWB_SYM_RESET;
		return s;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		pwb_sym_e sym;
		sym = PWB_SYM_NONE;
		next_r = r;
		next_r.bit_valid  = 1'b0;
		next_r.start_seen = 1'b0;
		next_r.reset_seen = 1'b0;
		next_r.attn_done  = 1'b0;

		// Own drive ends on its own count; a stalled line never extends it
		if (r.drive)
		begin
			if (r.drv_cnt != '0)
				next_r.drv_cnt = r.drv_cnt - 16'h0001;
			else
				next_r.drive = 1'b0;
		end

		if (swd_in)
			next_r.hi_cnt = (r.hi_cnt == {CNT_W{1'b1}}) ? r.hi_cnt : r.hi_cnt + 16'h0001;
		else
			next_r.hi_cnt = '0;

		case (r.state)
			PWB_WAIT_IDLE:
			begin
				if (r.hi_cnt >= 16'(MIN_IDLE_CYC))
					next_r.state = PWB_IDLE;
			end
			PWB_IDLE:
			begin
				if (line_low)
				begin
					next_r.state = PWB_LOW;
					// Joining a fresh fall counts as attention on an idle bus
					if (r.attn_pend && r.allowed)
					begin
						next_r.drive      = 1'b1;
						next_r.drive_attn = 1'b1;
						next_r.drv_cnt    = 16'(ATTN_CYC - 1);
						next_r.attn_pend  = 1'b0;
					end
					else if (send_one)
					begin
						// A one to send holds the line low for READ_ONE_CYC cycles from the fall
						next_r.drive      = 1'b1;
						next_r.drive_attn = 1'b0;
						next_r.drive_one  = 1'b1;
						next_r.drv_cnt    = 16'(READ_ONE_CYC - 1);
					end
				end
				else if (r.attn_pend && r.allowed)
				begin
					next_r.state      = PWB_LOW;
					next_r.drive      = 1'b1;
					next_r.drive_attn = 1'b1;
					next_r.drv_cnt    = 16'(ATTN_CYC - 1);
					next_r.attn_pend  = 1'b0;
				end
			end
			PWB_LOW:
			begin
				// Decision taken at the rising edge of the wire
				if (swd_in && !r.drive)
				begin
					sym = classify(low_cnt);
					next_r.state     = PWB_WAIT_IDLE;
					next_r.drive_one = 1'b0;
					next_r.drive_attn = 1'b0;
					case (sym)
						PWB_SYM_ZERO, PWB_SYM_ONE:
						begin
							// Training zeros pass as bits; no rate adjustment
							next_r.bit_valid = !r.drive_attn;
							next_r.bit_value = (sym == PWB_SYM_ONE);
							if (!r.allowed)
							begin
								if (r.bits_seen == 4'(BITS_AFTER_RESET - 1))
									next_r.allowed = 1'b1;
								next_r.bits_seen = r.bits_seen + 4'h1;
							end
						end
						PWB_SYM_START:
							next_r.start_seen = 1'b1;
						PWB_SYM_ATTN:
							next_r.attn_done = r.drive_attn;
						PWB_SYM_RESET:
						begin
							next_r.reset_seen = 1'b1;
							next_r.allowed    = 1'b0;
							next_r.bits_seen  = '0;
						end
						default:
							next_r.state = PWB_WAIT_IDLE;
					endcase
				end
			end
			default:
				next_r.state = PWB_WAIT_IDLE;
		endcase

		// Requests are latched so one that comes mid-symbol is not lost;
		// taken after the decode so one in the cycle an attention starts wins
		if (attn_req)
			next_r.attn_pend = 1'b1;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			r <= '0;
			r.state <= PWB_WAIT_IDLE;
		end
		else
			r <= next_r;
	end

	// Open drain: only ever pulls low, enable low while pulling
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			swd_out      <= 1'b1;
			swd_oe_n     <= 1'b1;
			bit_valid    <= 1'b0;
			bit_value    <= 1'b0;
			start_seen   <= 1'b0;
			reset_seen   <= 1'b0;
			attn_done    <= 1'b0;
			attn_busy    <= 1'b0;
			attn_allowed <= 1'b0;
		end
		else
		begin
			swd_out      <= 1'b0;
			swd_oe_n     <= !next_r.drive;
			bit_valid    <= next_r.bit_valid;
			bit_value    <= next_r.bit_value;
			start_seen   <= next_r.start_seen;
			reset_seen   <= next_r.reset_seen;
			attn_done    <= next_r.attn_done;
			attn_busy    <= next_r.attn_pend || next_r.drive_attn;
			attn_allowed <= next_r.allowed;
		end
	end
endmodule
`default_nettype wire

// File: pwb_pkg.sv
package pwb_pkg;
	// ----------------------------------------------------------------
	// Clock
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 40;

	// ----------------------------------------------------------------
	// Bus timing, nanoseconds as printed
	// ----------------------------------------------------------------
	localparam int MIN_IDLE_TIME_NS        = 11000;
	localparam int ACTIVITY_DETECT_NS      = 9600;
	localparam int MASTER_SHORT_MIN_NS     = 11800;
	localparam int MASTER_SHORT_MAX_NS     = 17000;
	localparam int MASTER_LONG_MIN_NS      = 35400;
	localparam int MASTER_LONG_MAX_NS      = 48900;
	localparam int SLAVE_READ_ONE_MIN_NS   = 28300;
	localparam int SLAVE_READ_ONE_MAX_NS   = 38300;
	localparam int MASTER_START_MIN_NS     = 80000;
	localparam int MASTER_START_MAX_NS     = 109000;
	localparam int SLAVE_ATTN_MIN_NS       = 165000;
	localparam int SLAVE_ATTN_MAX_NS       = 228000;
	localparam int RESET_MIN_NS            = 354000;

	// ----------------------------------------------------------------
	// Cycle counts at 40 MHz
	// ----------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam int MIN_IDLE_CYC  = (MIN_IDLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ACT_DET_CYC   = (ACTIVITY_DETECT_NS * CLK_MHZ) / 1000;
	// Slave drive lengths aim at mid range to absorb the clock tolerance
	localparam int READ_ONE_CYC  =
		((SLAVE_READ_ONE_MIN_NS + SLAVE_READ_ONE_MAX_NS) / 2 * CLK_MHZ) / 1000;
	localparam int ATTN_CYC      =
		((SLAVE_ATTN_MIN_NS + SLAVE_ATTN_MAX_NS) / 2 * CLK_MHZ) / 1000;
	// Classification thresholds, placed between the symbol ranges
	localparam int THR_ZERO_ONE  =
		((MASTER_SHORT_MAX_NS + SLAVE_READ_ONE_MIN_NS) / 2 * CLK_MHZ) / 1000;
	localparam int THR_ONE_START =
		((MASTER_LONG_MAX_NS + MASTER_START_MIN_NS) / 2 * CLK_MHZ) / 1000;
	localparam int THR_START_ATTN =
		((MASTER_START_MAX_NS + SLAVE_ATTN_MIN_NS) / 2 * CLK_MHZ) / 1000;
	localparam int THR_ATTN_RESET =
		((SLAVE_ATTN_MAX_NS + RESET_MIN_NS) / 2 * CLK_MHZ) / 1000;
	localparam int GLITCH_CYC    = 4;
	localparam int BITS_AFTER_RESET = 14;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PWB_SYM_NONE,
		PWB_SYM_ZERO,
		PWB_SYM_ONE,
		PWB_SYM_START,
		PWB_SYM_ATTN,
		PWB_SYM_RESET
	} pwb_sym_e;

	typedef enum logic [1:0] {
		PWB_WAIT_IDLE,
		PWB_IDLE,
		PWB_LOW
	} pwb_state_e;
endpackage

// File: pwb_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pwb_timer
	import pwb_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             run,
	output logic [CNT_W-1:0]      count
);
	// ----------------------------------------------------------------
	// Saturating duration counter, cleared whenever run drops
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst || !run)
			count <= '0;
		else if (count != {CNT_W{1'b1}})
			count <= count + 16'h0001;
	end
endmodule
`default_nettype wire

// File: pwb_slave_props.sv
`timescale 1ns/10ps
`default_nettype none
module pwb_slave_props
	import pwb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic swd_in,
	input wire logic swd_out,
	input wire logic swd_oe_n,
	input wire logic send_one,
	input wire logic attn_req,
	input wire logic attn_busy,
	input wire logic bit_valid,
	input wire logic bit_value,
	input wire logic start_seen,
	input wire logic reset_seen,
	input wire logic attn_done,
	input wire logic attn_allowed
);
	// ----------------------------------------------------------------
	// Length of the last low period seen on the wire
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] low_cnt;
	logic [CNT_W-1:0] low_len;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			low_cnt <= '0;
			low_len <= '0;
		end
		else
		begin
			low_cnt <= swd_in ? '0 : low_cnt + 1'h1;
			if (swd_in && low_cnt != '0)
				low_len <= low_cnt;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	valid_pulse_a: assert property (bit_valid |=> !bit_valid)
		else $error("bit_valid longer than one cycle");
	bit_class_a: assert property (bit_valid |-> bit_value == (low_len >= THR_ZERO_ONE))
		else $error("bit value does not match low length");
	start_class_a: assert property (start_seen |-> low_len >= THR_ONE_START)
		else $error("start reported for a short pulse");
	reset_class_a: assert property (reset_seen |-> low_len >= THR_ATTN_RESET)
		else $error("reset reported for a short pulse");
	sym_excl_a: assert property (bit_valid |-> !start_seen && !reset_seen)
		else $error("data bit reported with another symbol");
	allow_clear_a: assert property (reset_seen |=> !attn_allowed)
		else $error("attention allowed right after reset");
	attn_gate_a: assert property (attn_done |-> attn_allowed)
		else $error("attention sent while blocked");
	drive_len_a: assert property ($fell(swd_oe_n) |=> !swd_oe_n [*8])
		else $error("slave drive too short");
	reset_quiet_a: assert property (reset_seen |-> swd_oe_n)
		else $error("slave drives while reporting reset");
	cover property (bit_valid && bit_value);
	cover property (start_seen);
	cover property (reset_seen);
	cover property (attn_done);
endmodule
bind pwb_slave pwb_slave_props chk (.clk(clk), .rst(rst), .swd_in(swd_in), .swd_out(swd_out),
	.swd_oe_n(swd_oe_n), .send_one(send_one), .attn_req(attn_req), .attn_busy(attn_busy),
	.bit_valid(bit_valid), .bit_value(bit_value), .start_seen(start_seen),
	.reset_seen(reset_seen), .attn_done(attn_done), .attn_allowed(attn_allowed));
`default_nettype wire

// File: pwb_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module pwb_master_model
(
	input  wire logic clk,
	input  wire logic swd,
	output logic      drv_low
);
	// Master only pulls low; the pull-up makes the high level
	initial drv_low = 1'b0;
	task automatic pulse(input int n);
		int idle;
		idle = 0;
		// Idle must be seen before every symbol
		while (idle < 480)
		begin
			@(posedge clk);
			idle = swd ? idle + 1 : 0;
		end
		drv_low <= 1'b1;
		repeat (n) @(posedge clk);
		drv_low <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pwb_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        send_one = 1'b0;
	logic        attn_req = 1'b0;
	logic        clr = 1'b0;
	logic        m_drv;
	logic        swd_out;
	logic        swd_oe_n;
	logic        attn_busy;
	logic        bit_valid;
	logic        bit_value;
	logic        start_seen;
	logic        reset_seen;
	logic        attn_done;
	logic        attn_allowed;
	logic [4:0]  seen = 5'h0;
	logic [15:0] low_cnt = 16'h0;
	logic [15:0] low_len = 16'h0;
	int          cyc = 0;
	int          err_count = 0;
	int          total_checks = 0;
	wire         swd;
	always #12.5 clk = ~clk;
	assign swd = !(m_drv || (!swd_oe_n && !swd_out));
	pwb_slave dut (.clk(clk), .rst(rst), .swd_in(swd), .swd_out(swd_out), .swd_oe_n(swd_oe_n),
		.send_one(send_one), .attn_req(attn_req), .attn_busy(attn_busy),
		.bit_valid(bit_valid), .bit_value(bit_value), .start_seen(start_seen),
		.reset_seen(reset_seen), .attn_done(attn_done), .attn_allowed(attn_allowed));
	pwb_master_model mst (.clk(clk), .swd(swd), .drv_low(m_drv));
	// ----------------------------------------------------------------
	// Wire monitor, event collector and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		low_cnt <= swd ? 16'h0 : low_cnt + 16'h1;
		if (swd && low_cnt != 16'h0)
			low_len <= low_cnt;
		seen <= clr ? 5'h0 : seen | {attn_done, reset_seen, start_seen, bit_valid,
			bit_valid & bit_value};
		if (cyc == 90000)
		begin
			err_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One master symbol, then wait for the wire to rise and the report to land
	task automatic sym(input int n, input logic [4:0] exp);
		int i;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		mst.pulse(n);
		for (i = 0; i < 2000 && !swd; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		chk(seen, exp);
	endtask
	task automatic t_write();
		sym(560, 5'h02);
		sym(1680, 5'h03);
		sym(2, 5'h00);
	endtask
	task automatic t_start();
		sym(3800, 5'h04);
		sym(560, 5'h02);
	endtask
	task automatic t_read();
		send_one <= 1'b0;
		sym(560, 5'h02);
		chk(low_len < 16'h2a8, 1'h1);
		send_one <= 1'b1;
		sym(560, 5'h03);
		chk(low_len >= 16'h46c && low_len <= 16'h5fc, 1'h1);
		send_one <= 1'b0;
	endtask
	task automatic t_reset();
		sym(14800, 5'h08);
		chk(attn_allowed, 1'h0);
		repeat (13) sym(560, 5'h02);
		chk(attn_allowed, 1'h0);
		sym(560, 5'h02);
		chk(attn_allowed, 1'h1);
	endtask
	task automatic t_attn();
		int i;
		clr <= 1'b1;
		attn_req <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		attn_req <= 1'b0;
		for (i = 0; i < 2000 && swd; i++)
			@(posedge clk);
		chk(attn_busy, 1'h1);
		for (i = 0; i < 10000 && !swd; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		chk(low_len >= 16'h19c8 && low_len <= 16'h23a0, 1'h1);
		chk(seen, 5'h10);
		chk(attn_busy, 1'h0);
	endtask
	// Request lands on the edge the master falls, so the slave joins its bit
	task automatic t_join();
		int i;
		int idle;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		idle = 0;
		fork
			mst.pulse(560);
			begin
				while (idle < 479)
				begin
					@(posedge clk);
					idle = swd ? idle + 1 : 0;
				end
				attn_req <= 1'b1;
				@(posedge clk);
				attn_req <= 1'b0;
			end
		join
		chk(attn_busy, 1'h1);
		for (i = 0; i < 10000 && !swd; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		chk(low_len >= 16'h19c8 && low_len <= 16'h23a0, 1'h1);
		chk(seen, 5'h10);
		chk(attn_busy, 1'h0);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_write();
		t_start();
		t_read();
		t_reset();
		t_attn();
		t_join();
		print_verdict();
	end
endmodule
`default_nettype wire
